/* rtl/ubd_pkg.sv */
package ubd_pkg;

  // ---------------------------------------------------------------
  // Register map, byte offsets on the APB side
  // ---------------------------------------------------------------
  localparam logic [11:0] UBD_OFS_CONFIG = 12'h000;
  localparam logic [11:0] UBD_OFS_BASE = 12'h004;
  localparam logic [11:0] UBD_OFS_TOKEN = 12'h008;
  localparam logic [11:0] UBD_OFS_STATUS = 12'h00C;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int UBD_CFG_PINGPONG_LSB = 0;
  localparam int UBD_CFG_HOST_BIT = 2;
  localparam int UBD_STAT_BUSY_BIT = 0;
  localparam int UBD_STAT_ODD_BIT = 2;
  localparam int UBD_STAT_TX_BIT = 3;
  localparam int UBD_STAT_EP_LSB = 4;
  localparam logic [2:0] UBD_CONFIG_RST = 3'h0;
  localparam logic [7:0] UBD_BASE_RST = 8'h00;
  localparam logic [7:0] UBD_TOKEN_RST = 8'h00;
  localparam logic [7:0] UBD_STATUS_RST = 8'h00;

  // ---------------------------------------------------------------
  // Table geometry
  // ---------------------------------------------------------------
  localparam int UBD_TABLE_BYTES = 512;
  localparam int UBD_DESC_COUNT = 64;
  localparam int UBD_DESC_BYTES = 4;
  localparam logic [15:0] UBD_ADDR_WORD_OFS = 16'h0002;

  // Stream record: dest endpoint, index, status word, buffer address
  localparam int UBD_REC_W = 4 + 6 + 16 + 16;
  localparam int UBD_FIFO_DEPTH = 8;

  // ---------------------------------------------------------------
  // Ping-pong buffering modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    UBD_PP_NONE = 2'h0,
    UBD_PP_EP0_OUT = 2'h1,
    UBD_PP_ALL = 2'h2,
    UBD_PP_ALL_BUT_EP0 = 2'h3
  } ubd_pingpong_t;

  typedef enum logic [1:0] {
    UBD_ST_IDLE = 2'h0,
    UBD_ST_STAT = 2'h1,
    UBD_ST_ADDR = 2'h3,
    UBD_ST_PUSH = 2'h2
  } ubd_state_t;

endpackage

/* rtl/ubd_stream_if.sv */
`timescale 1ns/100ps
interface ubd_stream_if #(
  parameter int WIDTH = 8
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* rtl/ubd_fifo.sv */
`timescale 1ns/100ps
module ubd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
)(
  input wire logic clk,
  input wire logic reset_n,
  ubd_stream_if.snk in_s,
  ubd_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("ubd_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] wr_ptr_next;
  logic [AW:0] rd_ptr_reg;
  logic [AW:0] rd_ptr_next;
  logic full;
  logic empty;
  logic do_wr;
  logic do_rd;

  // ---------------------------------------------------------------
  // Flags and pointers
  // ---------------------------------------------------------------
  // Extra pointer bit tells full from empty without a counter
  always_comb
  begin
    empty = (wr_ptr_reg == rd_ptr_reg);
    full = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) && (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
    do_wr = in_s.valid && !full;
    do_rd = !empty && out_s.ready;
    wr_ptr_next = do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
    rd_ptr_next = do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
  end

  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem_reg[rd_ptr_reg[AW-1:0]];

  // Pointer registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_s.data;
  end
endmodule

/* rtl/ubd_index_map.sv */
`timescale 1ns/100ps
module ubd_index_map (
  input wire logic [1:0] pingpong,
  input wire logic [3:0] endpoint,
  input wire logic tx,
  input wire logic odd,
  input wire logic [7:0] base_ptr,
  output logic [5:0] index,
  output logic [15:0] desc_addr
);
  logic [6:0] idx_wide;

  // ---------------------------------------------------------------
  // Endpoint, direction and ping-pong onto a table slot
  // ---------------------------------------------------------------
  always_comb
  begin
    idx_wide = 7'h00;
    case (ubd_pkg::ubd_pingpong_t'(pingpong))
      ubd_pkg::UBD_PP_NONE:
        idx_wide = {2'h0, endpoint, tx};
      ubd_pkg::UBD_PP_EP0_OUT:
        // Only endpoint 0 receive alternates, everything else shifts up one
        if (endpoint == 4'h0 && !tx)
          idx_wide = {6'h00, odd};
        else
          idx_wide = 7'({1'b0, endpoint, tx} + 6'h01);
      ubd_pkg::UBD_PP_ALL:
        idx_wide = {1'b0, endpoint, tx, odd};
      default:
        if (endpoint == 4'h0)
          idx_wide = {6'h00, tx};
        else
          idx_wide = 7'({1'b0, endpoint, tx, odd} - 7'h02);
    endcase
    index = idx_wide[5:0];
  end

  // Base byte sits above the low bits; low base bit forced for 512-byte alignment
  assign desc_addr = {base_ptr[7:1], 1'b0, 8'h00} + {8'h00, index, 2'h0};
endmodule

/* rtl/ubd_descriptor_table.sv */
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
// Operation
// - The table lives in any free 512-byte block of data RAM aligned on a 512-byte boundary.
// - A base pointer register holds the table's upper address byte and software sets it before use.
// - Each descriptor is two 16-bit RAM words, a status word then a buffer start address word.
// - Up to 64 descriptors exist, numbered 0 to 63.
// - Buffer addresses are 16 bits, so only the first 64 Kbytes of RAM are reachable.
// - The descriptor chosen depends on endpoint number, direction and the two ping-pong bits.
// - In host mode every transfer uses the endpoint 0 descriptors and endpoint 0 control.
// - In host mode the source endpoint of each received packet appears in status bits 7:4.
// - In host mode each transmitted packet goes to the endpoint software wrote into the token register.
module ubd_descriptor_table #(
  parameter int FIFO_DEPTH = ubd_pkg::UBD_FIFO_DEPTH
)(
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transfer requests from the USB engine
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire logic [3:0] xfer_endpoint,
  input wire logic xfer_tx,
  input wire logic xfer_odd,
  input wire logic [3:0] xfer_remote_endpoint,
  // Data RAM read port
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_rvalid,
  // Fetched descriptors
  output logic desc_valid,
  input wire logic desc_ready,
  output logic [ubd_pkg::UBD_REC_W-1:0] desc_data,
  output logic endpoint_zero_control_sel
);

  initial
  begin
    if (FIFO_DEPTH < 2)
      $error("ubd_descriptor_table: FIFO_DEPTH below 2");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [2:0] usb_config_one_reg;
  logic [2:0] usb_config_one_next;
  logic [7:0] table_base_pointer_reg;
  logic [7:0] table_base_pointer_next;
  logic [7:0] token_reg_reg;
  logic [7:0] token_reg_next;
  logic [7:0] transfer_status_reg_reg;
  logic [7:0] transfer_status_reg_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  ubd_pkg::ubd_state_t state_reg;
  ubd_pkg::ubd_state_t state_next;
  logic xfer_ready_reg;
  logic xfer_ready_next;
  logic mem_req_reg;
  logic mem_req_next;
  logic [15:0] mem_addr_reg;
  logic [15:0] mem_addr_next;
  logic [15:0] desc_base_reg;
  logic [15:0] desc_base_next;
  logic [5:0] index_reg;
  logic [5:0] index_next;
  logic [15:0] status_word_reg;
  logic [15:0] status_word_next;
  logic [15:0] buffer_addr_reg;
  logic [15:0] buffer_addr_next;
  logic [3:0] dest_ep_reg;
  logic [3:0] dest_ep_next;
  logic ep0_sel_reg;
  logic ep0_sel_next;

  logic host_mode;
  logic [3:0] map_endpoint;
  logic [5:0] map_index;
  logic [15:0] map_addr;
  logic apb_write;
  logic apb_setup;
  logic addr_hit;

  ubd_stream_if #(.WIDTH(ubd_pkg::UBD_REC_W)) push_s ();
  ubd_stream_if #(.WIDTH(ubd_pkg::UBD_REC_W)) pop_s ();

  // ---------------------------------------------------------------
  // Descriptor slot lookup
  // ---------------------------------------------------------------
  assign host_mode = usb_config_one_reg[ubd_pkg::UBD_CFG_HOST_BIT];
  // Host side always walks endpoint 0 slots, whatever the remote end
  assign map_endpoint = host_mode ? 4'h0 : xfer_endpoint;

  ubd_index_map u_map (
    .pingpong(usb_config_one_reg[ubd_pkg::UBD_CFG_PINGPONG_LSB +: 2]),
    .endpoint(map_endpoint),
    .tx(xfer_tx),
    .odd(xfer_odd),
    .base_ptr(table_base_pointer_reg),
    .index(map_index),
    .desc_addr(map_addr)
  );

  // ---------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------
  // Answer one cycle after setup: pready rises in the first access cycle
  always_comb
  begin
    apb_setup = psel && !penable;
    apb_write = psel && penable && pready_reg && pwrite;
    addr_hit = 1'b0;
    usb_config_one_next = usb_config_one_reg;
    table_base_pointer_next = table_base_pointer_reg;
    token_reg_next = token_reg_reg;
    prdata_next = prdata_reg;
    pready_next = apb_setup;
    pslverr_next = 1'b0;
    if (paddr == ubd_pkg::UBD_OFS_CONFIG)
    begin
      addr_hit = 1'b1;
      prdata_next = {29'h0, usb_config_one_reg};
      if (apb_write)
        usb_config_one_next = pwdata[2:0];
    end
    else if (paddr == ubd_pkg::UBD_OFS_BASE)
    begin
      addr_hit = 1'b1;
      prdata_next = {24'h0, table_base_pointer_reg};
      if (apb_write)
        table_base_pointer_next = {pwdata[7:1], 1'b0};
    end
    else if (paddr == ubd_pkg::UBD_OFS_TOKEN)
    begin
      addr_hit = 1'b1;
      prdata_next = {24'h0, token_reg_reg};
      if (apb_write)
        token_reg_next = pwdata[7:0];
    end
    else if (paddr == ubd_pkg::UBD_OFS_STATUS)
    begin
      addr_hit = 1'b1;
      prdata_next = {24'h0, transfer_status_reg_reg[7:1], state_reg != ubd_pkg::UBD_ST_IDLE};
    end
    // Unmapped addresses read zero and flag an error
    if (apb_setup)
    begin
      if (!addr_hit)
        prdata_next = 32'h0000_0000;
      pslverr_next = !addr_hit;
    end
    else
    begin
      pslverr_next = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      usb_config_one_reg <= ubd_pkg::UBD_CONFIG_RST;
      table_base_pointer_reg <= ubd_pkg::UBD_BASE_RST;
      token_reg_reg <= ubd_pkg::UBD_TOKEN_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      usb_config_one_reg <= usb_config_one_next;
      table_base_pointer_reg <= table_base_pointer_next;
      token_reg_reg <= token_reg_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ---------------------------------------------------------------
  // Descriptor fetch sequencer
  // ---------------------------------------------------------------
  // Two RAM reads per request: status word, then buffer address word
  always_comb
  begin
    state_next = state_reg;
    xfer_ready_next = 1'b0;
    mem_req_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    desc_base_next = desc_base_reg;
    index_next = index_reg;
    status_word_next = status_word_reg;
    buffer_addr_next = buffer_addr_reg;
    dest_ep_next = dest_ep_reg;
    ep0_sel_next = ep0_sel_reg;
    transfer_status_reg_next = transfer_status_reg_reg;
    push_s.valid = 1'b0;
    push_s.data = {dest_ep_reg, index_reg, status_word_reg, buffer_addr_reg};
    case (state_reg)
      ubd_pkg::UBD_ST_IDLE:
        if (xfer_valid && !xfer_ready_reg)
        begin
          // Accept and latch the request, start the status-word read
          xfer_ready_next = 1'b1;
          index_next = map_index;
          desc_base_next = map_addr;
          mem_addr_next = map_addr;
          mem_req_next = 1'b1;
          ep0_sel_next = host_mode;
          // Host transmit targets the token endpoint; otherwise the local one
          dest_ep_next = (host_mode && xfer_tx) ? token_reg_reg[3:0] : xfer_endpoint;
          transfer_status_reg_next[7:4] = host_mode ? xfer_remote_endpoint : xfer_endpoint;
          transfer_status_reg_next[ubd_pkg::UBD_STAT_TX_BIT] = xfer_tx;
          transfer_status_reg_next[ubd_pkg::UBD_STAT_ODD_BIT] = xfer_odd;
          state_next = ubd_pkg::UBD_ST_STAT;
        end
      ubd_pkg::UBD_ST_STAT:
        if (mem_rvalid)
        begin
          status_word_next = mem_rdata;
          mem_addr_next = desc_base_reg + ubd_pkg::UBD_ADDR_WORD_OFS;
          mem_req_next = 1'b1;
          state_next = ubd_pkg::UBD_ST_ADDR;
        end
      ubd_pkg::UBD_ST_ADDR:
        if (mem_rvalid)
        begin
          buffer_addr_next = mem_rdata;
          state_next = ubd_pkg::UBD_ST_PUSH;
        end
      default:
      begin
        // Full FIFO holds the sequencer here, which stalls new requests
        push_s.valid = 1'b1;
        if (push_s.ready)
          state_next = ubd_pkg::UBD_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= ubd_pkg::UBD_ST_IDLE;
      xfer_ready_reg <= 1'b0;
      mem_req_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      desc_base_reg <= 16'h0000;
      index_reg <= 6'h00;
      status_word_reg <= 16'h0000;
      buffer_addr_reg <= 16'h0000;
      dest_ep_reg <= 4'h0;
      ep0_sel_reg <= 1'b0;
      transfer_status_reg_reg <= ubd_pkg::UBD_STATUS_RST;
    end
    else
    begin
      state_reg <= state_next;
      xfer_ready_reg <= xfer_ready_next;
      mem_req_reg <= mem_req_next;
      mem_addr_reg <= mem_addr_next;
      desc_base_reg <= desc_base_next;
      index_reg <= index_next;
      status_word_reg <= status_word_next;
      buffer_addr_reg <= buffer_addr_next;
      dest_ep_reg <= dest_ep_next;
      ep0_sel_reg <= ep0_sel_next;
      transfer_status_reg_reg <= transfer_status_reg_next;
    end
  end

  // ---------------------------------------------------------------
  // Output queue
  // ---------------------------------------------------------------
  ubd_fifo #(
    .WIDTH(ubd_pkg::UBD_REC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_s(push_s),
    .out_s(pop_s)
  );

  assign pop_s.ready = desc_ready;
  assign desc_valid = pop_s.valid;
  assign desc_data = pop_s.data;

  // Bus and handshake outputs
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign xfer_ready = xfer_ready_reg;
  assign mem_req = mem_req_reg;
  assign mem_addr = mem_addr_reg;
  assign endpoint_zero_control_sel = ep0_sel_reg;
endmodule

/* testbench/ubd_ram_model.sv */
`timescale 1ns/100ps
// Data RAM read port seen by the descriptor fetcher
module ubd_ram_model #(
  parameter logic [15:0] PATTERN = 16'hC3A5
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  output logic [15:0] mem_rdata,
  output logic mem_rvalid
);
  logic [15:0] addr_reg;
  logic [1:0] wait_reg;

  // Word contents derive from the 16-bit address; idle data toggles so stale reads show
  always @(posedge clk)
  begin
    mem_rvalid <= 1'h0;
    mem_rdata <= ~mem_rdata;
    if (!reset_n)
    begin
      wait_reg <= 2'h0;
      mem_rdata <= 16'h0000;
    end
    else if (mem_req)
    begin
      addr_reg <= mem_addr;
      wait_reg <= slow ? 2'h3 : 2'h1;
    end
    else if (wait_reg == 2'h1)
    begin
      mem_rvalid <= 1'h1;
      mem_rdata <= addr_reg ^ PATTERN;
      wait_reg <= 2'h0;
    end
    else if (wait_reg != 2'h0)
      wait_reg <= wait_reg - 2'h1;
  end
endmodule

/* testbench/ubd_descriptor_table_asserts.sv */
`timescale 1ns/100ps
module ubd_descriptor_table_asserts #(
  parameter int FIFO_DEPTH = 8
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic xfer_valid,
  input wire logic xfer_ready,
  input wire logic [3:0] xfer_endpoint,
  input wire logic xfer_tx,
  input wire logic xfer_odd,
  input wire logic [3:0] xfer_remote_endpoint,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_rdata,
  input wire logic mem_rvalid,
  input wire logic desc_valid,
  input wire logic desc_ready,
  input wire logic [ubd_pkg::UBD_REC_W-1:0] desc_data,
  input wire logic endpoint_zero_control_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // --------------------------------
  // Last requested RAM address
  // --------------------------------
  logic [15:0] last_addr_reg;
  logic [15:0] last_addr_next;

  always_comb
    last_addr_next = mem_req ? mem_addr : last_addr_reg;

  always_ff @(posedge clk)
    if (!reset_n)
      last_addr_reg <= 16'h0000;
    else
      last_addr_reg <= last_addr_next;

  // --------------------------------
  // Properties
  // --------------------------------
  property p_apb_answer; psel && !penable |=> pready; endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no pready after setup");
  property p_apb_pulse; pready |=> !pready; endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready too long");
  property p_err_map;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > ubd_pkg::UBD_OFS_STATUS);
  endproperty
  a_err_map: assert property (p_err_map) else $error("pslverr wrong");
  property p_err_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
  property p_take; xfer_ready |-> mem_req && $past(xfer_valid); endproperty
  a_take: assert property (p_take) else $error("take without status fetch");
  property p_take_pulse; xfer_ready |=> !xfer_ready; endproperty
  a_take_pulse: assert property (p_take_pulse) else $error("xfer_ready too long");
  property p_word_pair; mem_req && !xfer_ready |-> mem_addr == last_addr_reg + 16'h0002; endproperty
  a_word_pair: assert property (p_word_pair) else $error("address word not at status plus 2");
  property p_table_span; mem_req |-> mem_addr[8] == 1'h0 && mem_addr[0] == 1'h0; endproperty
  a_table_span: assert property (p_table_span) else $error("fetch outside 64 descriptors");
  property p_second; xfer_ready |-> ##[2:40] (mem_req && !xfer_ready); endproperty
  a_second: assert property (p_second) else $error("address word never fetched");

  c_err: cover property (pslverr);
  c_full: cover property (xfer_valid && desc_valid && !desc_ready);
  c_host: cover property (endpoint_zero_control_sel && mem_req);
endmodule

bind ubd_descriptor_table ubd_descriptor_table_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_endpoint(xfer_endpoint),
  .xfer_tx(xfer_tx), .xfer_odd(xfer_odd), .xfer_remote_endpoint(xfer_remote_endpoint),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
  .desc_valid(desc_valid), .desc_ready(desc_ready), .desc_data(desc_data),
  .endpoint_zero_control_sel(endpoint_zero_control_sel));

/* testbench/usb_buffer_descriptor_table_test.sv */
`timescale 1ns/100ps
module usb_buffer_descriptor_table_test;
  localparam logic [15:0] PAT = 16'hC3A5;
  typedef struct packed {
    logic [2:0] cfg;
    logic [7:0] base;
    logic [3:0] tok, ep;
    logic tx, odd;
    logic [3:0] rem;
    logic [5:0] idx;
    logic [3:0] dst;
  } ubd_row_t;

  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, slow, er, ok;
  logic xfer_valid, xfer_ready, xfer_tx, xfer_odd, mem_req, mem_rvalid;
  logic desc_valid, desc_ready, ep0_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] xfer_endpoint, xfer_remote_endpoint;
  logic [15:0] mem_addr, mem_rdata;
  logic [41:0] desc_data;
  logic [41:0] exp_q[$];
  int errors, cmp_count;
  ubd_row_t r;
  // Rows: inputs, then expected index and destination endpoint; host-mode rows use the endpoint 0 slots
  ubd_row_t rows[9] = '{
    '{3'h0, 8'h12, 4'h0, 4'h5, 1'h1, 1'h0, 4'h0, 6'h0B, 4'h5},
    '{3'h1, 8'h13, 4'h0, 4'h0, 1'h0, 1'h1, 4'h0, 6'h01, 4'h0},
    '{3'h1, 8'h20, 4'h0, 4'h0, 1'h1, 1'h0, 4'h0, 6'h02, 4'h0},
    '{3'h1, 8'h21, 4'h0, 4'h3, 1'h0, 1'h0, 4'h0, 6'h07, 4'h3},
    '{3'h2, 8'hFE, 4'h0, 4'hF, 1'h1, 1'h1, 4'h0, 6'h3F, 4'hF},
    '{3'h3, 8'h40, 4'h0, 4'h0, 1'h1, 1'h0, 4'h0, 6'h01, 4'h0},
    '{3'h3, 8'h41, 4'h0, 4'h7, 1'h0, 1'h1, 4'h0, 6'h1B, 4'h7},
    '{3'h4, 8'h80, 4'h3, 4'h9, 1'h1, 1'h0, 4'h6, 6'h01, 4'h3},
    '{3'h6, 8'h81, 4'hA, 4'h4, 1'h0, 1'h1, 4'hC, 6'h01, 4'h4}};

  ubd_descriptor_table #(.FIFO_DEPTH(8)) dut_u (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_endpoint(xfer_endpoint),
    .xfer_tx(xfer_tx), .xfer_odd(xfer_odd), .xfer_remote_endpoint(xfer_remote_endpoint),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid),
    .desc_valid(desc_valid), .desc_ready(desc_ready), .desc_data(desc_data),
    .endpoint_zero_control_sel(ep0_sel));

  ubd_ram_model #(.PATTERN(PAT)) ram_u (.clk(clk), .reset_n(reset_n), .slow(slow),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid));

  // --------------------------------
  // Shared tasks
  // --------------------------------
  task check(input logic [41:0] seen, input logic [41:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    if (errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    // A transfer that never completes counts against the run
    if (pready !== 1'h1)
      errors++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic xfer(input ubd_row_t x, input int lim);
    int n;
    @(posedge clk);
    xfer_valid <= 1'h1;
    xfer_endpoint <= x.ep;
    xfer_tx <= x.tx;
    xfer_odd <= x.odd;
    xfer_remote_endpoint <= x.rem;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (xfer_ready !== 1'h1 && n < lim);
    ok = (xfer_ready === 1'h1);
    xfer_valid <= 1'h0;
  endtask

  // Expected record: descriptor at base block plus four bytes per index
  task automatic push_exp(input ubd_row_t x);
    logic [15:0] a;
    a = {x.base[7:1], 1'h0, 8'h00} + {8'h00, x.idx, 2'h0};
    exp_q.push_back({x.dst, x.idx, a ^ PAT, (a + ubd_pkg::UBD_ADDR_WORD_OFS) ^ PAT});
  endtask

  task automatic pop;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (desc_valid !== 1'h1 && n < 100);
    check(desc_data, exp_q.pop_front());
    desc_ready <= 1'h1;
    @(posedge clk);
    desc_ready <= 1'h0;
  endtask

  // --------------------------------
  // Clock, watchdog and sequence
  // --------------------------------
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #200000;
    errors++;
    print_verdict;
  end

  initial
  begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, slow} = '0;
    {xfer_valid, xfer_endpoint, xfer_tx, xfer_odd, xfer_remote_endpoint, desc_ready} = '0;
    repeat (16) @(posedge clk);
    reset_n <= 1'h1;
    foreach (rows[i])
    begin
      r = rows[i];
      apb(1'h1, ubd_pkg::UBD_OFS_CONFIG, {29'h0, r.cfg});
      apb(1'h1, ubd_pkg::UBD_OFS_BASE, {24'h0, r.base});
      apb(1'h1, ubd_pkg::UBD_OFS_TOKEN, {28'h0, r.tok});
      xfer(r, 100);
      check(ok, 1'h1);
      push_exp(r);
      pop;
      check(ep0_sel, r.cfg[2]);
      apb(1'h0, ubd_pkg::UBD_OFS_STATUS, 32'h0);
      check({rd[7:2], rd[0]}, {r.cfg[2] ? r.rem : r.ep, r.tx, r.odd, 1'h0});
    end
    // Base bit 0 never shifts the 512-byte aligned table
    apb(1'h1, ubd_pkg::UBD_OFS_BASE, 32'hFF);
    apb(1'h0, ubd_pkg::UBD_OFS_BASE, 32'h0);
    check(rd, 32'hFE);
    // Status is read-only; unmapped offset refused
    apb(1'h1, ubd_pkg::UBD_OFS_STATUS, 32'hFF);
    apb(1'h0, ubd_pkg::UBD_OFS_STATUS, 32'h0);
    check(rd, 32'h0000_00C4);
    apb(1'h1, 12'h010, 32'hFF);
    check(er, 1'h1);
    apb(1'h0, 12'h010, 32'h0);
    check({er, rd}, {1'h1, 32'h0});
    // Fill the FIFO with a slow RAM and a stalled consumer
    // Ninth request is taken and parks in the sequencer, so only the tenth waits
    slow <= 1'h1;
    apb(1'h1, ubd_pkg::UBD_OFS_CONFIG, 32'h2);
    apb(1'h1, ubd_pkg::UBD_OFS_BASE, 32'h10);
    for (int k = 0; k < 10; k++)
    begin
      r = '{3'h2, 8'h10, 4'h0, k[3:0], k[0], 1'h1, 4'h0, {k[3:0], k[0], 1'h1}, k[3:0]};
      xfer(r, k < 9 ? 100 : 30);
      check(ok, k < 9);
      if (k < 9)
        push_exp(r);
    end
    repeat (9) pop;
    // Let the last pop settle before looking at the flag
    @(posedge clk);
    check(desc_valid, 1'h0);
    xfer(r, 100);
    push_exp(r);
    pop;
    // Second reset returns registers to zero
    @(posedge clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      apb(1'h0, 12'(k * 4), 32'h0);
      check(rd, 32'h0);
    end
    check(ep0_sel, 1'h0);
    print_verdict;
  end
endmodule
